/* shared/nfcq_pkg.sv */
package nfcq_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_CONFIG    = 7'h02;
	localparam logic [6:0] ADDR_THRESHOLD = 7'h03;
	localparam logic [6:0] ADDR_FILL      = 7'h04;
	localparam logic [6:0] ADDR_DATA      = 7'h05;
	// ----------------------------------------------------------------
	// queue_config field positions
	// ----------------------------------------------------------------
	localparam int CFG_CAP_BIT   = 7;
	localparam int CFG_NFULL_BIT = 6;
	localparam int CFG_NEMPT_BIT = 5;
	localparam int CFG_CLEAR_BIT = 4;
	localparam int CFG_THR8_BIT  = 2;
	localparam int CFG_FILL9_BIT = 1;
	localparam int CFG_FILL8_BIT = 0;
	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam logic [9:0] CAP_SMALL   = 10'h0ff;
	localparam logic [9:0] CAP_LARGE   = 10'h200;
	localparam int         DEPTH       = 512;
	localparam int         PTR_W       = 9;
	localparam logic       RST_CAP     = 1'b0;
	localparam logic [7:0] RST_THR     = 8'h00;
	localparam logic [9:0] RST_FILL    = 10'h000;
	localparam logic [7:0] RST_RDATA   = 8'h00;
	localparam logic [6:0] RST_ADDR    = 7'h00;
	localparam logic       RST_THR8    = 1'h0;
	localparam logic       RST_NFULL   = 1'h0;
	localparam logic       RST_NEMPT   = 1'h1;
endpackage

/* design/nfcq_mem.sv */
`timescale 1ns/1ps
// byte store: one write port, one asynchronous read port
module nfcq_mem
(
	// clock
	input  wire logic                        i_clk,
	// write side
	input  wire logic                        i_we,
	input  wire logic [nfcq_pkg::PTR_W-1:0]  i_waddr,
	input  wire logic [7:0]                  i_wdata,
	// read side
	input  wire logic [nfcq_pkg::PTR_W-1:0]  i_raddr,
	output logic      [7:0]                  o_rdata
);
	logic [7:0] mem [nfcq_pkg::DEPTH];

	// storage carries no reset; contents are only meaningful below the fill count
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
	end

	assign o_rdata = mem[i_raddr];
endmodule

/* design/nfcq_fifo.sv */
`timescale 1ns/1ps
// Summary of operation
// - capacity select bit 7 set gives 255 bytes, clear gives 512 bytes.
// - near-full flag bit 6 is one when capacity minus fill <= threshold.
// - near-empty flag bit 5 is one when fill <= threshold.
// - writing one to clear bit 4 empties queue; bit reads as zero.
// - config bit 2 is threshold bit 8, used only in 512-byte mode.
// - config bits 1:0 show fill count bits 9:8, meaningful in 512 mode.
// - fill count register at 04h shows low eight count bits, resets 00h.
// - data port write pushes and increments; read pops and decrements.
// - address pointer does not advance on accesses to data port 05h.
// - queue is an 8-bit port; reads return the oldest stored byte.
// - threshold register at 03h is host read/write, low threshold bits.
module nfcq_fifo
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// register access port
	input  wire logic       i_start,
	input  wire logic [6:0] i_start_addr,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_wdata,
	// read answer and pointer
	output logic      [7:0] o_rdata,
	output logic            o_rvalid,
	output logic      [6:0] o_addr,
	// status
	output logic            o_near_full_flag,
	output logic            o_near_empty_flag,
	output logic      [9:0] o_fill_count
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// address pointer
	logic [6:0]                 addr_r;
	logic [6:0]                 addr_nxt;
	// configuration
	logic                       cap_r;
	logic                       cap_nxt;
	logic                       thr8_r;
	logic                       thr8_nxt;
	logic [7:0]                 thr_r;
	logic [7:0]                 thr_nxt;
	// queue bookkeeping
	logic [9:0]                 fill_r;
	logic [9:0]                 fill_nxt;
	logic [nfcq_pkg::PTR_W-1:0] wptr_r;
	logic [nfcq_pkg::PTR_W-1:0] wptr_nxt;
	logic [nfcq_pkg::PTR_W-1:0] rptr_r;
	logic [nfcq_pkg::PTR_W-1:0] rptr_nxt;
	// read answer
	logic [7:0]                 rdata_r;
	logic [7:0]                 rdata_nxt;
	logic                       rvalid_r;
	logic                       rvalid_nxt;
	// alert flags
	logic                       nfull_r;
	logic                       nfull_nxt;
	logic                       nempt_r;
	logic                       nempt_nxt;

	// decode helpers
	logic [6:0]                 cur_addr;
	logic [9:0]                 cap_val;
	logic [9:0]                 cap_nv;
	logic [9:0]                 thr_full;
	logic                       is_full;
	logic                       is_empty;
	logic                       push;
	logic                       pop;
	logic                       clear;
	logic [7:0]                 mem_q;
	logic [nfcq_pkg::PTR_W-1:0] wptr_inc;
	logic [nfcq_pkg::PTR_W-1:0] rptr_inc;
	logic [7:0]                 cfg_byte;

	nfcq_mem u_mem
	(
		.i_clk   (i_clk),
		.i_we    (push),
		.i_waddr (wptr_r),
		.i_wdata (i_wdata),
		.i_raddr (rptr_r),
		.o_rdata (mem_q)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb
	begin
		cur_addr = i_start ? i_start_addr : addr_r;
		cap_val  = cap_r ? nfcq_pkg::CAP_SMALL : nfcq_pkg::CAP_LARGE;
		is_full  = (fill_r >= cap_val);
		is_empty = (fill_r == 10'h000);
		push     = i_wr && (cur_addr == nfcq_pkg::ADDR_DATA) && !is_full;
		pop      = i_rd && (cur_addr == nfcq_pkg::ADDR_DATA) && !is_empty;
		clear    = i_wr && (cur_addr == nfcq_pkg::ADDR_CONFIG) && i_wdata[nfcq_pkg::CFG_CLEAR_BIT];
		wptr_inc = wptr_r + 9'h001;
		rptr_inc = rptr_r + 9'h001;
	end

	// ----------------------------------------------------------------
	// address pointer
	// ----------------------------------------------------------------
	always_comb
	begin
		// i_start loads the pointer even when no access comes with it
		addr_nxt = cur_addr;

		// the data port holds the pointer so burst accesses keep reaching the queue
		if ((i_wr || i_rd) && (cur_addr != nfcq_pkg::ADDR_DATA))
			addr_nxt = cur_addr + 7'h01;
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			addr_r <= nfcq_pkg::RST_ADDR;
		else
			addr_r <= addr_nxt;
	end

	// ----------------------------------------------------------------
	// configuration and threshold
	// ----------------------------------------------------------------
	always_comb
	begin
		cap_nxt  = cap_r;
		thr8_nxt = thr8_r;
		thr_nxt  = thr_r;

		// capacity takes effect at once; stored bytes are not moved, so the host clears first
		if (i_wr)
		begin
			case (cur_addr)
				nfcq_pkg::ADDR_CONFIG:
				begin
					cap_nxt  = i_wdata[nfcq_pkg::CFG_CAP_BIT];
					thr8_nxt = i_wdata[nfcq_pkg::CFG_THR8_BIT];
				end
				nfcq_pkg::ADDR_THRESHOLD:
					thr_nxt = i_wdata;
				default:
				begin
					// fill count, data port and unmapped addresses leave the settings alone
					cap_nxt  = cap_r;
					thr8_nxt = thr8_r;
					thr_nxt  = thr_r;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cap_r  <= nfcq_pkg::RST_CAP;
			thr8_r <= nfcq_pkg::RST_THR8;
			thr_r  <= nfcq_pkg::RST_THR;
		end
		else
		begin
			cap_r  <= cap_nxt;
			thr8_r <= thr8_nxt;
			thr_r  <= thr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// queue pointers and fill count
	// ----------------------------------------------------------------
	always_comb
	begin
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		fill_nxt = fill_r;

		// pointers wrap over the whole store in both capacities; only the count decides fullness
		if (push)
			wptr_nxt = wptr_inc;
		if (pop)
			rptr_nxt = rptr_inc;
		// a refused push or pop falls to the default and leaves the count
		case ({push, pop})
			2'h2:    fill_nxt = fill_r + 10'h001;
			2'h1:    fill_nxt = fill_r - 10'h001;
			default: fill_nxt = fill_r;
		endcase

		// clear wins over a same-cycle push or pop and restarts both pointers
		if (clear)
		begin
			fill_nxt = nfcq_pkg::RST_FILL;
			wptr_nxt = '0;
			rptr_nxt = '0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			fill_r <= nfcq_pkg::RST_FILL;
			wptr_r <= '0;
			rptr_r <= '0;
		end
		else
		begin
			fill_r <= fill_nxt;
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	always_comb
	begin
		// clear bit and the spare bit 3 always read zero
		cfg_byte                          = 8'h00;
		cfg_byte[nfcq_pkg::CFG_CAP_BIT]   = cap_r;
		cfg_byte[nfcq_pkg::CFG_NFULL_BIT] = nfull_r;
		cfg_byte[nfcq_pkg::CFG_NEMPT_BIT] = nempt_r;
		cfg_byte[nfcq_pkg::CFG_CLEAR_BIT] = 1'h0;
		cfg_byte[nfcq_pkg::CFG_THR8_BIT]  = thr8_r;
		cfg_byte[nfcq_pkg::CFG_FILL9_BIT] = fill_r[9];
		cfg_byte[nfcq_pkg::CFG_FILL8_BIT] = fill_r[8];

		// rvalid strobes once per read, refused pops included
		rdata_nxt  = rdata_r;
		rvalid_nxt = i_rd;
		if (i_rd)
		begin
			case (cur_addr)
				nfcq_pkg::ADDR_CONFIG:    rdata_nxt = cfg_byte;
				nfcq_pkg::ADDR_THRESHOLD: rdata_nxt = thr_r;
				nfcq_pkg::ADDR_FILL:      rdata_nxt = fill_r[7:0];
				// an empty queue answers zero rather than a stale byte
				nfcq_pkg::ADDR_DATA:      rdata_nxt = is_empty ? nfcq_pkg::RST_RDATA : mem_q;
				default:                  rdata_nxt = nfcq_pkg::RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rdata_r  <= nfcq_pkg::RST_RDATA;
			rvalid_r <= 1'h0;
		end
		else
		begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// alert flags
	// ----------------------------------------------------------------
	always_comb
	begin
		// built from the next count so the flags and the count move on the same edge
		cap_nv    = cap_nxt ? nfcq_pkg::CAP_SMALL : nfcq_pkg::CAP_LARGE;

		// threshold bit 8 is ignored in the 255-byte mode
		thr_full  = {1'h0, (thr8_nxt && !cap_nxt), thr_nxt};
		// count can exceed 255 after a mode change without a clear; clamp the subtraction
		nfull_nxt = (fill_nxt >= cap_nv) || ((cap_nv - fill_nxt) <= thr_full);
		nempt_nxt = (fill_nxt <= thr_full);
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			nfull_r <= nfcq_pkg::RST_NFULL;
			nempt_r <= nfcq_pkg::RST_NEMPT;
		end
		else
		begin
			nfull_r <= nfull_nxt;
			nempt_r <= nempt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_rdata           = rdata_r;
	assign o_rvalid          = rvalid_r;
	assign o_addr            = addr_r;
	assign o_near_full_flag  = nfull_r;
	assign o_near_empty_flag = nempt_r;
	assign o_fill_count      = fill_r;
endmodule

/* test/nfcq_fifo_monitor.sv */
`timescale 1ns/1ps
module nfcq_mon
(
	// requests
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_start,
	input wire logic [6:0] i_start_addr,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] i_wdata,
	// answers
	input wire logic [7:0] o_rdata,
	input wire logic       o_rvalid,
	input wire logic [6:0] o_addr,
	input wire logic       o_near_full_flag,
	input wire logic       o_near_empty_flag,
	input wire logic [9:0] o_fill_count
);
	wire logic [6:0] a = i_start ? i_start_addr : o_addr;
	wire logic       acc = i_wr | i_rd;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// below 255 a push can never be refused in either capacity
	sequence s_push; i_wr && a == 7'h05 && o_fill_count < 10'h0ff; endsequence
	sequence s_pop; i_rd && a == 7'h05 && o_fill_count != 10'h000; endsequence
	property p_rv; i_rd |=> o_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_push; s_push |=> o_fill_count == $past(o_fill_count) + 10'h001; endproperty
	a_push: assert property (p_push) else $error("push count wrong");
	property p_pop; s_pop |=> o_fill_count == $past(o_fill_count) - 10'h001; endproperty
	a_pop: assert property (p_pop) else $error("pop count wrong");
	property p_empty; i_rd && a == 7'h05 && o_fill_count == 10'h000 |=> o_fill_count == 10'h000; endproperty
	a_empty: assert property (p_empty) else $error("empty pop moved count");
	property p_hold; acc && a == 7'h05 |=> o_addr == 7'h05; endproperty
	a_hold: assert property (p_hold) else $error("pointer moved on data port");
	property p_inc; acc && a != 7'h05 && a != 7'h7f |=> o_addr == $past(a) + 7'h01; endproperty
	a_inc: assert property (p_inc) else $error("pointer not advanced");
	property p_still; !acc |=> $stable(o_fill_count); endproperty
	a_still: assert property (p_still) else $error("count moved while idle");
	property p_ne; o_fill_count == 10'h000 |-> o_near_empty_flag; endproperty
	a_ne: assert property (p_ne) else $error("near empty low at zero");
	property p_clr; i_wr && a == 7'h02 && i_wdata[4] |=> o_fill_count == 10'h000; endproperty
	a_clr: assert property (p_clr) else $error("clear left bytes");
	property p_cnt; i_rd && a == 7'h04 |=> o_rdata == o_fill_count[7:0]; endproperty
	a_cnt: assert property (p_cnt) else $error("count read wrong");
	property p_nf; o_fill_count == 10'h200 |-> o_near_full_flag; endproperty
	a_nf: assert property (p_nf) else $error("near full low when full");
endmodule
bind nfcq_fifo nfcq_mon u_mon (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_start_addr(i_start_addr),
	.i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_addr(o_addr),
	.o_near_full_flag(o_near_full_flag), .o_near_empty_flag(o_near_empty_flag), .o_fill_count(o_fill_count));

/* test/nfcq_host.sv */
`timescale 1ns/1ps
module nfcq_host
(
	// clock and answer
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	// requests
	output logic            o_start,
	output logic      [6:0] o_start_addr,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_wdata
);
	initial
	begin
		{o_start, o_start_addr, o_wr, o_rd, o_wdata} = '0;
	end
	// capacity is rewritten by every write to the config register, clear bit set or not
	task automatic acc(input logic s, input logic w, input logic [6:0] ad, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		{o_start, o_start_addr, o_wr, o_rd, o_wdata} = {s, ad, w, !w, d};
		@(negedge i_clk);
		{o_start, o_wr, o_rd, o_wdata} = {2'b00, 1'b0, ~d};
		q = i_rdata;
	endtask
endmodule

/* test/nfcq_fifo_tb_top.sv */
`timescale 1ns/1ps
module nfcq_fifo_tb_top;
	logic       i_clk = 1'b0;
	logic       i_reset = 1'b1;
	logic       st, wr, rd, rv, nf, ne;
	logic [6:0] sa, ad;
	logic [7:0] wd, rdat, q;
	logic [9:0] fc;
	int         n_fail = 0;
	int         check_count = 0;
	always #2 i_clk = ~i_clk;
	nfcq_host host (.i_clk(i_clk), .i_rdata(rdat), .o_start(st), .o_start_addr(sa), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
	nfcq_fifo dut (.i_clk(i_clk), .i_reset(i_reset), .i_start(st), .i_start_addr(sa), .i_wr(wr), .i_rd(rd),
		.i_wdata(wd), .o_rdata(rdat), .o_rvalid(rv), .o_addr(ad), .o_near_full_flag(nf), .o_near_empty_flag(ne),
		.o_fill_count(fc));
	task chk(input string s, input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task w(input logic [6:0] a, input logic [7:0] d);
		host.acc(1'b1, 1'b1, a, d, q);
	endtask
	task r(input logic [6:0] a);
		host.acc(1'b1, 1'b0, a, 8'h00, q);
	endtask
	task push(input int n);
		for (int k = 0; k < n; k++)
			w(7'h05, k[7:0]);
	endtask
	task t_order;
		r(7'h02);
		chk("config", q, 10'h020);
		w(7'h03, 8'h02);
		push(3);
		chk("near empty", ne, 10'h000);
		r(7'h05);
		chk("oldest", q, 10'h000);
		chk("rvalid", rv, 10'h001);
		chk("pointer", ad, 10'h005);
		host.acc(1'b0, 1'b0, 7'h00, 8'h00, q);
		chk("burst pop", q, 10'h001);
		chk("near empty", ne, 10'h001);
		r(7'h03);
		chk("threshold", q, 10'h002);
		host.acc(1'b0, 1'b0, 7'h00, 8'h00, q);
		chk("next reg", q, 10'h001);
	endtask
	task t_large;
		w(7'h02, 8'h14);
		chk("cleared", fc, 10'h000);
		push(253);
		chk("near full", nf, 10'h000);
		push(1);
		chk("near full", nf, 10'h001);
		push(4);
		chk("near empty", ne, 10'h001);
		push(1);
		chk("near empty", ne, 10'h000);
		push(254);
		chk("full count", fc, 10'h200);
		r(7'h02);
		chk("config", q, 10'h046);
		r(7'h04);
		chk("low count", q, 10'h000);
	endtask
	task t_small;
		w(7'h02, 8'h94);
		push(3);
		chk("near empty", ne, 10'h000);
		push(249);
		chk("near full", nf, 10'h000);
		push(1);
		chk("near full", nf, 10'h001);
		push(3);
		chk("capped", fc, 10'h0ff);
		r(7'h02);
		chk("config", q, 10'h0c4);
		w(7'h02, 8'h10);
		r(7'h05);
		chk("empty pop", q, 10'h000);
		chk("empty count", fc, 10'h000);
	endtask
	initial
	begin
		repeat (12) @(posedge i_clk);
		@(negedge i_clk) i_reset = 1'b0;
		t_order;
		t_large;
		t_small;
		print_verdict;
	end
	// about 785 accesses of two cycles each need under 10 us
	initial
	begin
		#100000;
		n_fail++;
		print_verdict;
	end
endmodule
